// ---- hw/def_pkg.sv ----
// Package for the converter event status flag block: register map, bit layout,
// link check limits and the structs that carry bus, event and state signals.
// Assumes a classic Wishbone slave with 32-bit data and byte-wide registers.
package def_pkg;

  // ----------------------------------------------------------------
  // Register map (word indices; byte address is four times the index)
  // ----------------------------------------------------------------
  localparam int unsigned ADR_W          = 12;
  localparam int unsigned IDX_W          = 10;
  localparam logic [IDX_W-1:0] IDX_MODE_BASE  = 10'h020;
  localparam logic [IDX_W-1:0] IDX_FLAGS_BASE = 10'h024;
  localparam logic [IDX_W-1:0] IDX_CH0_FLAGS  = 10'h025;
  localparam logic [IDX_W-1:0] IDX_CH1_FLAGS  = 10'h026;
  localparam logic [IDX_W-1:0] IDX_CHECKS     = 10'h030;
  localparam logic [1:0]       SLOT_NONE      = 2'h3;

  // ----------------------------------------------------------------
  // Bit positions and masks
  // ----------------------------------------------------------------
  localparam int unsigned BYTE_W        = 8;
  localparam int unsigned NFLAG         = 24;
  localparam int unsigned CH1_PAT_BIT   = 2;
  localparam int unsigned CH0_PAT_BIT   = 0;
  localparam int unsigned PWR_BIT       = 7;
  localparam int unsigned BLANK_BIT     = 5;
  localparam int unsigned LOCK_BIT      = 3;
  localparam int unsigned ROTATE_BIT    = 2;
  localparam int unsigned WINDOW_BIT    = 1;
  localparam int unsigned TRIP_BIT      = 0;
  localparam int unsigned CHK_DELAY_BIT = 5;
  localparam int unsigned CHK_WIN_BIT   = 4;
  localparam int unsigned CHK_COMBO_BIT = 3;
  localparam int unsigned CHK_K_BIT     = 2;
  localparam int unsigned CHK_SUB_BIT   = 1;
  localparam int unsigned CHK_INTP_BIT  = 0;
  localparam logic [23:0] FLAG_MASK     = 24'hAF_AF05;
  localparam logic [7:0]  CHK_MASK      = 8'h3F;
  localparam logic [7:0]  FLAGS_RST     = 8'h00;

  // ----------------------------------------------------------------
  // Link configuration limits
  // ----------------------------------------------------------------
  localparam logic [5:0] K_SUPP_A      = 6'h10;
  localparam logic [5:0] K_SUPP_B      = 6'h20;
  localparam logic [2:0] WIN_LIMIT_MAX = 3'h3;
  localparam logic [2:0] SUBCLASS_MAX  = 3'h1;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic             cyc;
    logic             stb;
    logic             we;
    logic [ADR_W-1:0] adr;
    logic [3:0]       sel;
    logic [31:0]      dat;
  } def_wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } def_wb_rsp_t;

  typedef struct packed {
    logic ch1_pattern_check_fail;
    logic ch0_pattern_check_fail;
    logic ch0_power_limit_error;
    logic ch0_blanking_complete;
    logic ch0_align_locked;
    logic ch0_align_rotated;
    logic ch0_phase_out_of_window;
    logic ch0_align_tripped;
    logic ch1_power_limit_error;
    logic ch1_blanking_complete;
    logic ch1_align_locked;
    logic ch1_align_rotated;
    logic ch1_phase_out_of_window;
    logic ch1_align_tripped;
  } def_events_t;

  typedef struct packed {
    logic [5:0] multiframe_clock_delay;
    logic [5:0] frames_per_multiframe;
    logic [2:0] window_limit;
    logic       combo_supported;
    logic [2:0] subclass;
    logic [3:0] interpolation;
  } def_link_cfg_t;

  typedef struct packed {
    logic [NFLAG-1:0] mode;
    logic [NFLAG-1:0] lat;
    logic [NFLAG-1:0] ev_prev;
    logic [7:0]       chk;
    logic             ack;
    logic [31:0]      rdat;
  } def_state_t;

endpackage : def_pkg

// ---- hw/def_event_flags.sv ----
// Event status flags and interrupt request of a dual-channel converter.
// Assumes event and link configuration inputs come from logic on clk.
//
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/1ps

module def_event_flags (
  // Clock and reset
  input  wire logic           clk,
  input  wire logic           resetn,
  // Register bus
  input  def_pkg::def_wb_req_t wb_req,
  output def_pkg::def_wb_rsp_t wb_rsp,
  // Event sources and link configuration
  input  def_pkg::def_events_t   events,
  input  def_pkg::def_link_cfg_t link_cfg,
  // Interrupt request
  output logic                irq_n
);

  // ----------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------
  // Maps an index to one of three consecutive byte slots starting at a base.
  function automatic logic [1:0] slot_of(input logic [def_pkg::IDX_W-1:0] idx,
                                         input logic [def_pkg::IDX_W-1:0] base);
    logic [def_pkg::IDX_W-1:0] off;
    off = idx - base;
    if (idx >= base && off < 10'h003) begin
      slot_of = off[1:0];
    end else begin
      slot_of = def_pkg::SLOT_NONE;
    end
  endfunction : slot_of

  function automatic logic [7:0] link_checks(input def_pkg::def_link_cfg_t c);
    logic [7:0] r;
    r = 8'h00;
    r[def_pkg::CHK_DELAY_BIT] = c.multiframe_clock_delay > c.frames_per_multiframe;
    r[def_pkg::CHK_WIN_BIT]   = c.window_limit > def_pkg::WIN_LIMIT_MAX;
    r[def_pkg::CHK_COMBO_BIT] = ~c.combo_supported;
    r[def_pkg::CHK_K_BIT]     = !(c.frames_per_multiframe == def_pkg::K_SUPP_A ||
                                  c.frames_per_multiframe == def_pkg::K_SUPP_B);
    r[def_pkg::CHK_SUB_BIT]   = c.subclass > def_pkg::SUBCLASS_MAX;
    r[def_pkg::CHK_INTP_BIT]  = !(c.interpolation == 4'h1 || c.interpolation == 4'h2 ||
                                  c.interpolation == 4'h4 || c.interpolation == 4'h8);
    link_checks = r & def_pkg::CHK_MASK;
  endfunction : link_checks

  // ----------------------------------------------------------------
  // Event vector
  // ----------------------------------------------------------------
  def_pkg::def_state_t           st;
  def_pkg::def_state_t           st_next;
  logic [def_pkg::NFLAG-1:0]     ev_vec;
  logic [def_pkg::NFLAG-1:0]     rise;
  logic [def_pkg::NFLAG-1:0]     clr;
  logic [def_pkg::IDX_W-1:0]     idx;
  logic [1:0]                    flag_slot;
  logic [1:0]                    mode_slot;
  logic                          wr_hit;

  localparam int unsigned B1 = def_pkg::BYTE_W;
  localparam int unsigned B2 = 2 * def_pkg::BYTE_W;

  // Flags sit in three bytes: pattern checks, channel 0, channel 1.
  always_comb begin
    ev_vec = '0;
    ev_vec[def_pkg::CH1_PAT_BIT]     = events.ch1_pattern_check_fail;
    ev_vec[def_pkg::CH0_PAT_BIT]     = events.ch0_pattern_check_fail;
    ev_vec[B1 + def_pkg::PWR_BIT]    = events.ch0_power_limit_error;
    ev_vec[B1 + def_pkg::BLANK_BIT]  = events.ch0_blanking_complete;
    ev_vec[B1 + def_pkg::LOCK_BIT]   = events.ch0_align_locked;
    ev_vec[B1 + def_pkg::ROTATE_BIT] = events.ch0_align_rotated;
    ev_vec[B1 + def_pkg::WINDOW_BIT] = events.ch0_phase_out_of_window;
    ev_vec[B1 + def_pkg::TRIP_BIT]   = events.ch0_align_tripped;
    ev_vec[B2 + def_pkg::PWR_BIT]    = events.ch1_power_limit_error;
    ev_vec[B2 + def_pkg::BLANK_BIT]  = events.ch1_blanking_complete;
    ev_vec[B2 + def_pkg::LOCK_BIT]   = events.ch1_align_locked;
    ev_vec[B2 + def_pkg::ROTATE_BIT] = events.ch1_align_rotated;
    ev_vec[B2 + def_pkg::WINDOW_BIT] = events.ch1_phase_out_of_window;
    ev_vec[B2 + def_pkg::TRIP_BIT]   = events.ch1_align_tripped;
  end

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // A write takes effect on the edge where the master sees ack high.
  assign idx       = wb_req.adr[def_pkg::ADR_W-1:2];
  assign flag_slot = slot_of(idx, def_pkg::IDX_FLAGS_BASE);
  assign mode_slot = slot_of(idx, def_pkg::IDX_MODE_BASE);
  assign wr_hit    = wb_req.cyc & wb_req.stb & wb_req.we & wb_req.sel[0] & st.ack;
  assign rise      = ev_vec & ~st.ev_prev;

  for (genvar g = 0; g < 3; g++) begin : g_clr
    assign clr[g*def_pkg::BYTE_W +: def_pkg::BYTE_W] =
      (wr_hit && flag_slot == 2'(g)) ? wb_req.dat[7:0] : 8'h00;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [def_pkg::NFLAG-1:0] shown;
    logic [7:0]                rbyte;
    shown   = '0;
    rbyte   = 8'h00;
    st_next = st;
    st_next.ev_prev = ev_vec;
    // A rising edge in the clearing cycle wins over the clear.
    st_next.lat = ((st.lat & ~clr) | (rise & st.mode)) & def_pkg::FLAG_MASK;
    if (wr_hit && mode_slot != def_pkg::SLOT_NONE) begin
      st_next.mode[mode_slot*def_pkg::BYTE_W +: def_pkg::BYTE_W] =
        wb_req.dat[7:0] & def_pkg::FLAG_MASK[mode_slot*def_pkg::BYTE_W +: def_pkg::BYTE_W];
    end
    st_next.chk = link_checks(link_cfg);
    st_next.ack = wb_req.cyc & wb_req.stb & ~st.ack;
    // Live events where latch mode is off, stored flags where it is on.
    shown = ((st.mode & st.lat) | (~st.mode & ev_vec)) & def_pkg::FLAG_MASK;
    if (flag_slot != def_pkg::SLOT_NONE) begin
      rbyte = shown[flag_slot*def_pkg::BYTE_W +: def_pkg::BYTE_W];
    end else if (mode_slot != def_pkg::SLOT_NONE) begin
      rbyte = st.mode[mode_slot*def_pkg::BYTE_W +: def_pkg::BYTE_W];
    end else if (idx == def_pkg::IDX_CHECKS) begin
      rbyte = st.chk;
    end
    if (st_next.ack) begin
      st_next.rdat = {24'h00_0000, rbyte};
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st.mode    <= {3{def_pkg::FLAGS_RST}};
      st.lat     <= {3{def_pkg::FLAGS_RST}};
      st.ev_prev <= {3{def_pkg::FLAGS_RST}};
      st.chk     <= def_pkg::FLAGS_RST;
      st.ack     <= 1'b0;
      st.rdat    <= 32'h0000_0000;
    end else begin
      st <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign wb_rsp.ack = st.ack;
  assign wb_rsp.dat = st.rdat;
  assign irq_n      = ~|(st.lat & st.mode);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  logic rd_take;
  assign rd_take = st_next.ack & ~wb_req.we;

  sequence s_enabled_rise;
    |(rise & st.mode);
  endsequence

  sequence s_clear_all;
    wr_hit && ((st.lat & st.mode & ~clr) == '0) && !(|(rise & st.mode));
  endsequence

  a_rise_pulls_irq: assert property (s_enabled_rise |=> !irq_n)
    else $error("enabled event edge did not pull the interrupt low");

  a_rise_sets_flag: assert property ((rise[B1 + def_pkg::LOCK_BIT] && st.mode[B1 + def_pkg::LOCK_BIT])
    |=> st.lat[B1 + def_pkg::LOCK_BIT])
    else $error("latched flag not set on rising edge");

  a_one_clears_flag: assert property ((|clr) && !(|(rise & st.mode & clr))
    |=> (st.lat & $past(clr)) == '0)
    else $error("write of one did not clear flag");

  a_zero_keeps_flag: assert property (wr_hit |=> ($past(st.lat & ~clr) & ~st.lat) == '0)
    else $error("write of zero disturbed a latched flag");

  a_irq_released: assert property (s_clear_all |=> irq_n)
    else $error("interrupt not released after last flag cleared");

  a_live_read_ch0: assert property ((rd_take && idx == def_pkg::IDX_CH0_FLAGS
    && st.mode[15:8] == 8'h00) |=> wb_rsp.dat[7:0] == $past(ev_vec[15:8]))
    else $error("live status read differs from event state");

  a_latched_read_ch1: assert property ((rd_take && idx == def_pkg::IDX_CH1_FLAGS
    && st.mode[23:16] == 8'hAF) |=> wb_rsp.dat[7:0] == $past(st.lat[23:16]))
    else $error("latched read differs from stored flags");

  a_prbs_reserved: assert property ((rd_take && idx == def_pkg::IDX_FLAGS_BASE)
    |=> (wb_rsp.dat[7:0] & 8'hFA) == 8'h00)
    else $error("reserved pattern status bits read nonzero");

  a_chan_reserved: assert property ((rd_take && (idx == def_pkg::IDX_CH0_FLAGS
    || idx == def_pkg::IDX_CH1_FLAGS)) |=> (wb_rsp.dat[7:0] & 8'h50) == 8'h00)
    else $error("reserved channel flag bits read nonzero");

  a_check_reserved: assert property ((rd_take && idx == def_pkg::IDX_CHECKS)
    |=> wb_rsp.dat[7:6] == 2'b00)
    else $error("reserved check bits read nonzero");

  a_delay_check: assert property ((link_cfg.multiframe_clock_delay
    > link_cfg.frames_per_multiframe) |=> st.chk[def_pkg::CHK_DELAY_BIT])
    else $error("delay above K not flagged");

  a_k_check: assert property ((link_cfg.frames_per_multiframe == def_pkg::K_SUPP_B)
    |=> !st.chk[def_pkg::CHK_K_BIT])
    else $error("supported K value flagged");

  a_subclass_check: assert property ((link_cfg.subclass == 3'h2)
    |=> st.chk[def_pkg::CHK_SUB_BIT])
    else $error("unsupported subclass not flagged");

  a_ack_single: assert property (wb_rsp.ack |=> !wb_rsp.ack)
    else $error("ack held longer than one cycle");

endmodule : def_event_flags

// ---- dv/tb.sv ----
// Self-checking bench for the converter event status flag block.
// Assumes def_pkg and def_event_flags are compiled first; the bench drives every input port.
`timescale 1ns/1ps

module tb;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic                   clk;
  logic                   resetn;
  def_pkg::def_wb_req_t   wb_req;
  def_pkg::def_wb_rsp_t   wb_rsp;
  def_pkg::def_events_t   events;
  def_pkg::def_link_cfg_t link_cfg;
  logic                   irq_n;
  int                     bad_count = 0;
  int                     num_checks = 0;
  int                     cycles = 0;

  def_event_flags def_event_flags_i (
    .clk      (clk),
    .resetn   (resetn),
    .wb_req   (wb_req),
    .wb_rsp   (wb_rsp),
    .events   (events),
    .link_cfg (link_cfg),
    .irq_n    (irq_n)
  );

  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  // A run that outlives the ceiling is treated as a hang.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      bad_count = bad_count + 1;
      end_sim();
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    num_checks = num_checks + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  // One classic cycle; entered right after a rising edge, leaves one idle cycle behind.
  task automatic bus(input logic we, input logic [9:0] idx, input logic [3:0] sel,
                     input logic [7:0] wd, output logic [31:0] rdat);
    wb_req <= '{cyc: 1'h1, stb: 1'h1, we: we, adr: {idx, 2'h0}, sel: sel,
                dat: {24'h00_0000, wd}};
    do @(posedge clk); while (wb_rsp.ack !== 1'h1);
    rdat = wb_rsp.dat;
    wb_req.cyc <= 1'h0;
    wb_req.stb <= 1'h0;
    @(posedge clk);
  endtask : bus

  task automatic wr(input logic [9:0] idx, input logic [7:0] wd);
    logic [31:0] dummy;
    bus(1'h1, idx, 4'h1, wd, dummy);
  endtask : wr

  task automatic rd_chk(input logic [9:0] idx, input logic [31:0] exp, input string msg);
    logic [31:0] r;
    bus(1'h0, idx, 4'h0, 8'h00, r);
    chk(r, exp, msg);
  endtask : rd_chk

  // Reads the three flag bytes as {channel 1, channel 0, pattern}.
  task automatic rd3(output logic [23:0] v);
    logic [31:0] r;
    for (int k = 0; k < 3; k++) begin
      bus(1'h0, def_pkg::IDX_FLAGS_BASE + 10'(k), 4'h0, 8'h00, r);
      v[8*k +: 8] = r[7:0];
    end
  endtask : rd3

  // Drives the events from a vector laid out like the three flag bytes.
  task automatic set_ev(input logic [23:0] v);
    events <= {v[2], v[0], v[15], v[13], v[11], v[10], v[9], v[8],
               v[23], v[21], v[19], v[18], v[17], v[16]};
  endtask : set_ev

  task automatic cfg(input logic [5:0] d, input logic [5:0] k, input logic [2:0] w,
                     input logic c, input logic [2:0] s, input logic [3:0] i,
                     input logic [7:0] exp);
    link_cfg <= {d, k, w, c, s, i};
    repeat (2) @(posedge clk);
    rd_chk(def_pkg::IDX_CHECKS, {24'h00_0000, exp}, "link check byte");
  endtask : cfg

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_live();
    logic [23:0] v;
    for (int i = 0; i < 24; i++) begin
      if (def_pkg::FLAG_MASK[i]) begin
        set_ev(24'h00_0001 << i);
        rd3(v);
        chk(32'(v), 32'h0000_0001 << i, "live flag position");
      end
    end
    set_ev(24'hFF_FFFF);
    rd3(v);
    chk(32'(v), 32'h00AF_AF05, "reserved bits read zero");
    chk(32'(irq_n), 32'h0000_0001, "no request in live mode");
    set_ev(24'h00_0000);
    $display("test live status done");
  endtask : t_live

  task automatic t_latch();
    logic [23:0] v;
    logic [7:0]  b;
    logic [31:0] r;
    wr(def_pkg::IDX_MODE_BASE, 8'h05);
    wr(def_pkg::IDX_CH0_FLAGS - 10'h004, 8'hAF);
    wr(def_pkg::IDX_CH1_FLAGS - 10'h004, 8'hAF);
    bus(1'h1, def_pkg::IDX_MODE_BASE, 4'h0, 8'h00, r);
    wr(10'h023, 8'hFF);
    rd_chk(def_pkg::IDX_MODE_BASE, 32'h0000_0005, "mode write with sel low ignored");
    rd_chk(10'h023, 32'h0000_0000, "unmapped reads zero");
    rd3(v);
    chk(32'(v), 32'h0000_0000, "rising edge in live mode not stored");
    for (int i = 0; i < 24; i++) begin
      if (def_pkg::FLAG_MASK[i]) begin
        b = 8'h01 << (i % 8);
        set_ev(24'h00_0001 << i);
        @(posedge clk);
        set_ev(24'h00_0000);
        repeat (2) @(posedge clk);
        chk(32'(irq_n), 32'h0000_0000, "request low while latched");
        rd3(v);
        chk(32'(v), 32'h0000_0001 << i, "flag holds after event falls");
        wr(def_pkg::IDX_FLAGS_BASE + 10'(i / 8), ~b);
        rd3(v);
        chk(32'(v), 32'h0000_0001 << i, "zeros leave flag set");
        wr(def_pkg::IDX_FLAGS_BASE + 10'(i / 8), b);
        rd3(v);
        chk(32'(v), 32'h0000_0000, "one clears flag");
        chk(32'(irq_n), 32'h0000_0001, "request released");
      end
    end
    set_ev(24'h84_0004);
    @(posedge clk);
    set_ev(24'h00_0000);
    wr(def_pkg::IDX_CH1_FLAGS, 8'h80);
    chk(32'(irq_n), 32'h0000_0000, "request held by remaining flags");
    wr(def_pkg::IDX_FLAGS_BASE, 8'h04);
    wr(def_pkg::IDX_CH1_FLAGS, 8'h04);
    chk(32'(irq_n), 32'h0000_0001, "request released after last clear");
    $display("test latched flags done");
  endtask : t_latch

  task automatic t_checks();
    cfg(6'h00, 6'h10, 3'h0, 1'h1, 3'h0, 4'h1, 8'h00);
    cfg(6'h10, 6'h10, 3'h3, 1'h1, 3'h1, 4'h2, 8'h00);
    cfg(6'h11, 6'h10, 3'h0, 1'h1, 3'h0, 4'h4, 8'h20);
    cfg(6'h00, 6'h20, 3'h4, 1'h1, 3'h0, 4'h8, 8'h10);
    cfg(6'h00, 6'h18, 3'h0, 1'h0, 3'h0, 4'h1, 8'h0C);
    cfg(6'h00, 6'h10, 3'h0, 1'h1, 3'h2, 4'h3, 8'h03);
    cfg(6'h00, 6'h10, 3'h0, 1'h1, 3'h0, 4'h0, 8'h01);
    cfg(6'h3F, 6'h00, 3'h7, 1'h0, 3'h7, 4'hF, 8'h3F);
    wr(def_pkg::IDX_CHECKS, 8'h00);
    rd_chk(def_pkg::IDX_CHECKS, 32'h0000_003F, "check byte is read only");
    cfg(6'h00, 6'h10, 3'h0, 1'h1, 3'h0, 4'h1, 8'h00);
    $display("test link checks done");
  endtask : t_checks

  task automatic t_rereset();
    logic [23:0] v;
    set_ev(24'h00_0800);
    @(posedge clk);
    set_ev(24'h00_0000);
    repeat (2) @(posedge clk);
    chk(32'(irq_n), 32'h0000_0000, "lock flag latched");
    resetn <= 1'h0;
    repeat (2) @(posedge clk);
    chk(32'(irq_n), 32'h0000_0001, "request high in reset");
    resetn <= 1'h1;
    @(posedge clk);
    rd_chk(def_pkg::IDX_CH0_FLAGS - 10'h004, 32'h0000_0000, "mode cleared by reset");
    rd3(v);
    chk(32'(v), 32'h0000_0000, "flags cleared by reset");
    $display("test second reset done");
  endtask : t_rereset

  initial begin
    resetn = 1'h0;
    wb_req = '0;
    events = '0;
    link_cfg = {6'h00, 6'h10, 3'h0, 1'h1, 3'h0, 4'h1};
    repeat (2) @(posedge clk);
    resetn <= 1'h1;
    @(posedge clk);
    chk(32'(irq_n), 32'h0000_0001, "request idle after reset");
    rd_chk(def_pkg::IDX_CHECKS, 32'h0000_0000, "supported link setup");
    t_live();
    t_latch();
    t_checks();
    t_rereset();
    end_sim();
  end
endmodule : tb
